/* hw/apdv_regs_defines.vh */
// register offsets, field positions, reset values and timing counts for the amplifier control bank
`ifndef APDV_REGS_DEFINES_VH
`define APDV_REGS_DEFINES_VH

`define APDV_OFS_MAKER       8'h00
`define APDV_OFS_PART_LOW    8'h01
`define APDV_OFS_PART_HIGH   8'h02
`define APDV_OFS_REVISION    8'h03
`define APDV_OFS_POWER       8'h04
`define APDV_OFS_AMP         8'h05
`define APDV_OFS_CONV        8'h06
`define APDV_OFS_LEFT_VOL    8'h07
`define APDV_OFS_RIGHT_VOL   8'h08

// identity values are arbitrary
`define APDV_ID_MAKER        8'h5a
`define APDV_ID_PART_LOW     8'h3c
`define APDV_ID_PART_HIGH    8'h6e
`define APDV_ID_REVISION     8'h02

`define APDV_RST_POWER       8'ha1
`define APDV_RST_AMP         8'h8a
`define APDV_RST_CONV        8'h02
`define APDV_RST_VOL         8'h40

// writable bits per register, reserved bits read as zero
`define APDV_MASK_POWER      8'hbd
`define APDV_MASK_AMP        8'hbb
`define APDV_MASK_CONV       8'hf7

`define APDV_PWR_AUTO_SLEEP  7
`define APDV_PWR_THERMAL_OFF 5
`define APDV_PWR_MONO        4
`define APDV_PWR_RIGHT_OFF   3
`define APDV_PWR_LEFT_OFF    2
`define APDV_PWR_MASTER_OFF  0

`define APDV_AMP_LOW_POWER   7
`define APDV_AMP_RIGHT_INV   5
`define APDV_AMP_LEFT_INV    4
`define APDV_AMP_LOW_EMI     3
`define APDV_AMP_GAIN_HI     1
`define APDV_AMP_GAIN_LO     0

`define APDV_CONV_RAMP_BYP   7
`define APDV_CONV_RIGHT_MUTE 6
`define APDV_CONV_LEFT_MUTE  5
`define APDV_CONV_HIGHPASS   4
`define APDV_CONV_RATE_HI    2
`define APDV_CONV_RATE_LO    0

`define APDV_READ_NONE       8'h00

// soft ramp: one volume code per step time
`define APDV_CLK_PERIOD_NS   8
`define APDV_RAMP_STEP_NS    1000
`define APDV_RAMP_CYCLES     ((`APDV_RAMP_STEP_NS + `APDV_CLK_PERIOD_NS - 1) / `APDV_CLK_PERIOD_NS)

`endif

/* hw/apdv_regs.v */
// control register bank of the stereo amplifier: id, power, amplifier, converter and volume registers
//
// Overview of operation
// R01 - four read-only identity bytes sit at offsets 0x00 to 0x03 and writes to them change nothing.
// R02 - power bit 7 enables automatic sleep when set and resets to enabled.
// R03 - power bit 5 switches the thermal sensor off when set and resets to off.
// R04 - power bits 3 and 2 switch the right and left channel off when set and on when clear.
// R05 - power bit 0 is the master software power-down and resets to powered down.
// R06 - power bit 4 selects bridged single-channel operation when set and resets to stereo.
// R07 - amplifier bit 7 puts the converter in low power mode and resets to 1.
// R08 - amplifier bits 5 and 4 invert the right and left converter output when set.
// R09 - amplifier bit 3 selects the reduced-slew low-emission edge rate and resets to 1.
// R10 - the two-bit analog gain selects 13, 16, 19 or 21 dB for codes 0 to 3 and resets to code 2.
// R11 - converter bit 7 applies volume at once when set and ramps toward it when clear.
// R12 - converter bits 6 and 5 mute the right and left channel when set.
// R13 - converter bit 4 inserts the high-pass filter when set and resets to bypassed.
// R14 - the three-bit rate field selects the input sample-rate range, codes 0 to 5.
// R15 - the left volume byte spans +24 dB at 0x00 in 0.375 dB steps, 0 dB at 0x40, mute at 0xff.
// R16 - the right volume byte uses the same coding for the right channel and resets to 0 dB.
`timescale 1ns/1ps
`include "apdv_regs_defines.vh"

module apdv_regs (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata,
  output reg        rd_valid,
  output wire       auto_sleep_enable,
  output wire       thermal_sensor_off,
  output wire       mono_select,
  output wire       right_channel_off,
  output wire       left_channel_off,
  output wire       master_software_off,
  output wire       converter_low_power,
  output wire       right_output_invert,
  output wire       left_output_invert,
  output wire       low_emi_edge,
  output wire [1:0] analog_gain_select,
  output wire       volume_ramp_bypass,
  output wire       right_mute,
  output wire       left_mute,
  output wire       highpass_enable,
  output wire [2:0] sample_rate_range,
  output wire [7:0] left_volume_code,
  output wire [7:0] right_volume_code,
  output wire       volume_settled
);

  localparam integer RAMP_LAST_INT = `APDV_RAMP_CYCLES - 1;
  localparam [15:0]  RAMP_LAST     = RAMP_LAST_INT[15:0];

  reg  [7:0]  power_control;
  reg  [7:0]  amp_output_control;
  reg  [7:0]  converter_control;
  reg  [7:0]  left_volume;
  reg  [7:0]  right_volume;
  reg  [15:0] ramp_count;
  reg         ramp_tick;
  reg  [7:0]  next_rdata;
  reg         settled;
  wire        wr_power;
  wire        wr_amp;
  wire        wr_conv;
  wire        wr_left;
  wire        wr_right;
  wire [7:0]  vol_target [0:1];
  wire [7:0]  next_target [0:1];
  wire [7:0]  vol_applied [0:1];
  wire [1:0]  vol_done;

  // write decode; identity offsets have no storage so writes there fall away
  assign wr_power = wr_en && (addr == `APDV_OFS_POWER);
  assign wr_amp   = wr_en && (addr == `APDV_OFS_AMP);
  assign wr_conv  = wr_en && (addr == `APDV_OFS_CONV);
  assign wr_left  = wr_en && (addr == `APDV_OFS_LEFT_VOL);
  assign wr_right = wr_en && (addr == `APDV_OFS_RIGHT_VOL);

  // reserved bits are masked on write so they always read zero
  always @(posedge clk) begin
    if (!rst_n)
      power_control <= `APDV_RST_POWER;  // see R02 see R03 see R05 see R06
    else if (wr_power)
      power_control <= wdata & `APDV_MASK_POWER;  // see R04
  end

  always @(posedge clk) begin
    if (!rst_n)
      amp_output_control <= `APDV_RST_AMP;  // see R07 see R09 see R10
    else if (wr_amp)
      amp_output_control <= wdata & `APDV_MASK_AMP;  // see R08
  end

  always @(posedge clk) begin
    if (!rst_n)
      converter_control <= `APDV_RST_CONV;  // see R13
    else if (wr_conv)
      converter_control <= wdata & `APDV_MASK_CONV;  // see R12 see R14
  end

  always @(posedge clk) begin
    if (!rst_n)
      left_volume <= `APDV_RST_VOL;  // see R15
    else if (wr_left)
      left_volume <= wdata;  // see R15
  end

  always @(posedge clk) begin
    if (!rst_n)
      right_volume <= `APDV_RST_VOL;  // see R16
    else if (wr_right)
      right_volume <= wdata;  // see R16
  end

  // read mux; unmapped offsets read zero
  always @* begin
    case (addr)
      `APDV_OFS_MAKER:     next_rdata = `APDV_ID_MAKER;      // see R01
      `APDV_OFS_PART_LOW:  next_rdata = `APDV_ID_PART_LOW;   // see R01
      `APDV_OFS_PART_HIGH: next_rdata = `APDV_ID_PART_HIGH;  // see R01
      `APDV_OFS_REVISION:  next_rdata = `APDV_ID_REVISION;   // see R01
      `APDV_OFS_POWER:     next_rdata = power_control;
      `APDV_OFS_AMP:       next_rdata = amp_output_control;
      `APDV_OFS_CONV:      next_rdata = converter_control;
      `APDV_OFS_LEFT_VOL:  next_rdata = left_volume;
      `APDV_OFS_RIGHT_VOL: next_rdata = right_volume;
      default:             next_rdata = `APDV_READ_NONE;
    endcase
  end

  // a read and a write in one cycle return the old value
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata    <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en)
        rdata <= next_rdata;
    end
  end

  // shared step timer so both channels move in lockstep
  always @(posedge clk) begin
    if (!rst_n) begin
      ramp_count <= 16'h0000;
      ramp_tick  <= 1'b0;
    end else begin
      ramp_tick <= (ramp_count == RAMP_LAST);
      if (ramp_count == RAMP_LAST)
        ramp_count <= 16'h0000;
      else
        ramp_count <= ramp_count + 16'h0001;
    end
  end

  assign vol_target[0]  = left_volume;
  assign vol_target[1]  = right_volume;
  assign next_target[0] = wr_left ? wdata : left_volume;
  assign next_target[1] = wr_right ? wdata : right_volume;

  // applied volume per channel; mute code 0xff is reached by ramping too, trading speed for no clicks
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg  [7:0] applied;
      reg  [7:0] next_applied;
      always @* begin
        next_applied = applied;
        if (converter_control[`APDV_CONV_RAMP_BYP])
          next_applied = vol_target[ch];  // see R11
        else if (ramp_tick && (applied < vol_target[ch]))
          next_applied = applied + 8'h01;  // see R11
        else if (ramp_tick && (applied > vol_target[ch]))
          next_applied = applied - 8'h01;  // see R11
      end
      always @(posedge clk) begin
        if (!rst_n)
          applied <= `APDV_RST_VOL;
        else
          applied <= next_applied;
      end
      assign vol_applied[ch] = applied;
      // next values, so the registered flag agrees with the codes in the same cycle
      assign vol_done[ch]    = (next_applied == next_target[ch]);
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_n)
      settled <= 1'b1;
    else
      settled <= &vol_done;
  end

  assign left_volume_code  = vol_applied[0];  // see R15
  assign right_volume_code = vol_applied[1];  // see R16
  assign volume_settled    = settled;

  assign auto_sleep_enable   = power_control[`APDV_PWR_AUTO_SLEEP];   // see R02
  assign thermal_sensor_off  = power_control[`APDV_PWR_THERMAL_OFF];  // see R03
  assign mono_select         = power_control[`APDV_PWR_MONO];         // see R06
  assign right_channel_off   = power_control[`APDV_PWR_RIGHT_OFF];    // see R04
  assign left_channel_off    = power_control[`APDV_PWR_LEFT_OFF];     // see R04
  assign master_software_off = power_control[`APDV_PWR_MASTER_OFF];   // see R05

  assign converter_low_power = amp_output_control[`APDV_AMP_LOW_POWER];  // see R07
  assign right_output_invert = amp_output_control[`APDV_AMP_RIGHT_INV];  // see R08
  assign left_output_invert  = amp_output_control[`APDV_AMP_LEFT_INV];   // see R08
  assign low_emi_edge        = amp_output_control[`APDV_AMP_LOW_EMI];    // see R09
  assign analog_gain_select  = amp_output_control[`APDV_AMP_GAIN_HI:`APDV_AMP_GAIN_LO];  // see R10

  assign volume_ramp_bypass = converter_control[`APDV_CONV_RAMP_BYP];    // see R11
  assign right_mute         = converter_control[`APDV_CONV_RIGHT_MUTE];  // see R12
  assign left_mute          = converter_control[`APDV_CONV_LEFT_MUTE];   // see R12
  assign highpass_enable    = converter_control[`APDV_CONV_HIGHPASS];    // see R13
  // codes 6 and 7 are stored as written; the rate logic downstream must treat them as unsupported
  assign sample_rate_range  = converter_control[`APDV_CONV_RATE_HI:`APDV_CONV_RATE_LO];  // see R14

endmodule // apdv_regs

/* verif/apdv_regs_properties.sv */
// assertions on the register port, control outputs and volume ramp of the control bank
`timescale 1ns/1ps
`include "apdv_regs_defines.vh"
module apdv_regs_properties (
  input wire       clk,
  input wire       rst_n,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire       rd_valid,
  input wire       auto_sleep_enable,
  input wire       thermal_sensor_off,
  input wire       mono_select,
  input wire       right_channel_off,
  input wire       left_channel_off,
  input wire       master_software_off,
  input wire       converter_low_power,
  input wire       right_output_invert,
  input wire       left_output_invert,
  input wire       low_emi_edge,
  input wire [1:0] analog_gain_select,
  input wire       volume_ramp_bypass,
  input wire       right_mute,
  input wire       left_mute,
  input wire       highpass_enable,
  input wire [2:0] sample_rate_range,
  input wire [7:0] left_volume_code,
  input wire [7:0] right_volume_code,
  input wire       volume_settled
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RD_PULSE: assert property (rd_valid == $past(rd_en & rst_n))
    else $error("read valid not one cycle after read");
  AST_ID_READ: assert property (rd_en && addr == `APDV_OFS_MAKER |=> rdata == `APDV_ID_MAKER)
    else $error("maker byte misread");
  AST_POWER: assert property (wr_en && addr == `APDV_OFS_POWER |=> {auto_sleep_enable, 1'b0,
    thermal_sensor_off, mono_select, right_channel_off, left_channel_off, 1'b0, master_software_off}
    == ($past(wdata) & `APDV_MASK_POWER)) else $error("power outputs wrong after write");
  AST_AMP: assert property (wr_en && addr == `APDV_OFS_AMP |=> {converter_low_power, 1'b0,
    right_output_invert, left_output_invert, low_emi_edge, 1'b0, analog_gain_select}
    == ($past(wdata) & `APDV_MASK_AMP)) else $error("amplifier outputs wrong after write");
  AST_CONV: assert property (wr_en && addr == `APDV_OFS_CONV |=> {volume_ramp_bypass, right_mute,
    left_mute, highpass_enable, 1'b0, sample_rate_range} == ($past(wdata) & `APDV_MASK_CONV))
    else $error("converter outputs wrong after write");
  // hard volume: applied code follows the write two samples later at most
  AST_LVOL_HARD: assert property (wr_en && addr == `APDV_OFS_LEFT_VOL && volume_ramp_bypass
    |=> ##1 left_volume_code == $past(wdata, 2)) else $error("left volume not applied at once");
  AST_RVOL_HARD: assert property (wr_en && addr == `APDV_OFS_RIGHT_VOL && volume_ramp_bypass
    |=> ##1 right_volume_code == $past(wdata, 2)) else $error("right volume not applied at once");
  AST_RAMP_STEP: assert property (!volume_ramp_bypass && !$past(volume_ramp_bypass)
    && !$past(volume_ramp_bypass, 2) && $changed(left_volume_code)
    |-> left_volume_code == $past(left_volume_code) + 8'h01 || left_volume_code + 8'h01 == $past(left_volume_code))
    else $error("left volume ramp jumped");
  AST_RST_VALUES: assert property ($rose(rst_n) |-> left_volume_code == `APDV_RST_VOL
    && right_volume_code == `APDV_RST_VOL && volume_settled
    && {auto_sleep_enable, 1'b0, thermal_sensor_off, mono_select, right_channel_off, left_channel_off, 1'b0,
    master_software_off} == `APDV_RST_POWER
    && {converter_low_power, 1'b0, right_output_invert, left_output_invert, low_emi_edge, 1'b0,
    analog_gain_select} == `APDV_RST_AMP
    && {volume_ramp_bypass, right_mute, left_mute, highpass_enable, 1'b0, sample_rate_range} == `APDV_RST_CONV)
    else $error("outputs not at reset values");
  AST_SETTLED_HOLD: assert property (volume_settled && !(wr_en && (addr == `APDV_OFS_LEFT_VOL
    || addr == `APDV_OFS_RIGHT_VOL)) |=> $stable(left_volume_code) && $stable(right_volume_code))
    else $error("volume moved while settled");
endmodule // apdv_regs_properties
bind apdv_regs apdv_regs_properties u_apdv_regs_properties (
  .clk                 (clk),
  .rst_n               (rst_n),
  .wr_en               (wr_en),
  .rd_en               (rd_en),
  .addr                (addr),
  .wdata               (wdata),
  .rdata               (rdata),
  .rd_valid            (rd_valid),
  .auto_sleep_enable   (auto_sleep_enable),
  .thermal_sensor_off  (thermal_sensor_off),
  .mono_select         (mono_select),
  .right_channel_off   (right_channel_off),
  .left_channel_off    (left_channel_off),
  .master_software_off (master_software_off),
  .converter_low_power (converter_low_power),
  .right_output_invert (right_output_invert),
  .left_output_invert  (left_output_invert),
  .low_emi_edge        (low_emi_edge),
  .analog_gain_select  (analog_gain_select),
  .volume_ramp_bypass  (volume_ramp_bypass),
  .right_mute          (right_mute),
  .left_mute           (left_mute),
  .highpass_enable     (highpass_enable),
  .sample_rate_range   (sample_rate_range),
  .left_volume_code    (left_volume_code),
  .right_volume_code   (right_volume_code),
  .volume_settled      (volume_settled)
);

/* verif/apdv_regs_tb.sv */
// self-checking bench for the amplifier control register bank
`timescale 1ns/1ps
`include "apdv_regs_defines.vh"
module apdv_regs_tb;
  logic       clk = 0, rst_n = 0, wr_en = 0, rd_en = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  wire  [7:0] rdata, lvol, rvol;
  wire        rd_valid, settled;
  logic [7:0] m [0:8];
  logic [7:0] q [$];
  int         n_fail = 0, n_compared = 0, i, n;
  apdv_regs u_apdv_regs (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rd_valid(rd_valid), .auto_sleep_enable(), .thermal_sensor_off(), .mono_select(),
    .right_channel_off(), .left_channel_off(), .master_software_off(), .converter_low_power(),
    .right_output_invert(), .left_output_invert(), .low_emi_edge(), .analog_gain_select(),
    .volume_ramp_bypass(), .right_mute(), .left_mute(), .highpass_enable(), .sample_rate_range(),
    .left_volume_code(lvol), .right_volume_code(rvol), .volume_settled(settled));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // writable bits; reserved bits and id bytes keep their value
  function automatic logic [7:0] msk(input logic [7:0] a);
    return a == 8'h04 ? 8'hbd : a == 8'h05 ? 8'hbb : a == 8'h06 ? 8'hf7 : 8'hff;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1;
    addr <= a;
    wdata <= d;
    if (a > 8'h03 && a < 8'h09) m[a] = d & msk(a);
    @(posedge clk);
    wr_en <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rd_en <= 1;
    addr <= a;
    q.push_back(a < 8'h09 ? m[a] : 8'h00);
    @(posedge clk);
    rd_en <= 0;
  endtask
  always @(posedge clk) if (rd_valid === 1'b1) chk(rdata, q.size() > 0 ? q.pop_front() : 8'hxx);
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done;
  end
  initial begin
    void'($urandom(64521));
    m = '{`APDV_ID_MAKER, `APDV_ID_PART_LOW, `APDV_ID_PART_HIGH, `APDV_ID_REVISION, 8'ha1, 8'h8a, 8'h02, 8'h40, 8'h40};
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 10; i++) rd(i[7:0]);
    $display("test reset done");
    for (i = 0; i < 9; i++) wr(i[7:0], 8'hff);
    for (i = 0; i < 9; i++) rd(i[7:0]);
    for (i = 0; i < 6; i++) begin
      wr(8'h05, {6'h00, i[1:0]});
      wr(8'h06, i[7:0]);
      rd(8'h05);
      rd(8'h06);
    end
    repeat (40) begin
      wr(8'($urandom % 10), 8'($urandom));
      rd(8'($urandom % 10));
    end
    $display("test access done");
    wr(8'h06, 8'h80);
    wr(8'h07, 8'h40);
    wr(8'h08, 8'h00);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h42);
    @(posedge clk);
    chk({7'h00, settled}, 8'h00);
    n = 0;
    // two codes away at one step per tick: no earlier than one tick period
    while (lvol !== 8'h42 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, n >= 120 && n <= 260}, 8'h01);
    chk({7'h00, settled}, 8'h01);
    wr(8'h06, 8'h80);
    wr(8'h07, 8'hff);
    repeat (2) @(posedge clk);
    chk(lvol, 8'hff);
    chk(rvol, 8'h00);
    $display("test ramp done");
    test_done;
  end
endmodule // apdv_regs_tb
